/* design/sas_adc_sequencer.sv */
// top: register file and sequencing of the 8-bit successive approximation converter
// Behaviour
// - writing one to start bit begins conversion of selected channel
// - start bit clears itself once conversion begins, reads back zero
// - after conversion time, store result, set end flag, pulse interrupt
// - reading the result register clears the end flag
// - busy set at start, cleared at finish and on stop entry
// - restart before read clears end flag, old result kept until done
// - channel codes 2 to 5 pick analog channels 2 to 5, rest reserved
// - bit 4 of control one disables analog inputs when one
// - ladder bit zero connects only during conversion, one always connected
// - time field codes 2 to 6 pick 78 to 1248 fc periods
// - stop mode forces control registers to reset and blocks writes
// - undefined and unstable status bits read here as zero
// - stop entry aborts conversion, clears result and ladder, no restart
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sas_adc_sequencer
  import sas_pkg::*;
#(
  parameter int NB = sas_pkg::SAR_BITS
) (
  input wire logic clk_i, // fc, 50 MHz
  input wire logic reset_n_i, // async reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic stop_mode_i, // high while in stop mode
  input wire logic cmp_i, // comparator decision
  output logic [NB-1:0] dac_code_o, // trial code to the ladder
  output logic ladder_on_o, // ladder connected
  output logic sample_o, // sample-hold tracking, during conversion
  output logic [3:0] chan_sel_o, // one-hot analog_channel_2..5
  output logic ain_enable_o, // analog inputs enabled
  output logic conversion_done_irq_o // one-cycle completion pulse
);
  import sas_pkg::*;

  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [NB-1:0] result;
  logic end_flag;
  logic busy_flag;
  sas_state_t state;
  logic start_req;
  logic wr_cr1;
  logic wr_cr2;
  logic rd_result;
  logic step_tick;
  logic sar_done;
  logic [NB-1:0] sar_trial;
  logic [10:0] step_len;
  logic stop_q;
  logic stop_entry;

  assign wr_cr1 = wr_i && addr_i == ADDR_CONTROL_ONE && !stop_mode_i;
  assign wr_cr2 = wr_i && addr_i == ADDR_CONTROL_TWO && !stop_mode_i;
  assign rd_result = rd_i && addr_i == ADDR_RESULT;
  assign start_req = wr_cr1 && wdata_i[CR1_START_BIT];
  assign stop_entry = stop_mode_i && !stop_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode_i;
    end
  end

  always_comb begin
    case (control_two[CR2_TIME_LSB +: 3])
      TIME_78: step_len = 11'(CONV_FC_78 / NB);
      TIME_156: step_len = 11'(CONV_FC_156 / NB);
      TIME_312: step_len = 11'(CONV_FC_312 / NB);
      TIME_624: step_len = 11'(CONV_FC_624 / NB);
      TIME_1248: step_len = 11'(CONV_FC_1248 / NB);
      // reserved codes run at the shortest legal time rather than hang
      default: step_len = 11'(CONV_FC_78 / NB);
    endcase
  end

  // stop forces reset values and blocks writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_one <= CR1_RESET;
    end else if (stop_mode_i) begin
      control_one <= CR1_RESET;
    end else if (wr_cr1) begin
      control_one <= {1'b0, wdata_i[6:0]};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_two <= CR2_RESET;
    end else if (stop_mode_i) begin
      control_two <= CR2_RESET;
    end else if (wr_cr2) begin
      control_two <= {2'b00, wdata_i[5:0]};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SAS_IDLE;
    end else if (stop_mode_i) begin
      state <= SAS_IDLE;
    end else begin
      case (state)
        SAS_IDLE: begin
          if (start_req) begin
            state <= SAS_RUN;
          end
        end
        SAS_RUN: begin
          if (sar_done) begin
            state <= SAS_IDLE;
          end
        end
        default: state <= SAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_flag <= 1'b0;
    end else if (stop_mode_i) begin
      busy_flag <= 1'b0;
    end else if (start_req && state == SAS_IDLE) begin
      busy_flag <= 1'b1;
    end else if (state == SAS_RUN && sar_done) begin
      busy_flag <= 1'b0;
    end
  end

  // end flag on completion; set wins over a read clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      end_flag <= 1'b0;
    end else if (stop_mode_i) begin
      end_flag <= 1'b0;
    end else if (state == SAS_RUN && sar_done) begin
      end_flag <= 1'b1;
    end else if (rd_result || (start_req && state == SAS_IDLE)) begin
      end_flag <= 1'b0;
    end
  end

  // latch result; old value held through a restart
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result <= RESULT_RESET;
    end else if (stop_entry) begin
      result <= RESULT_RESET;
    end else if (state == SAS_RUN && sar_done) begin
      result <= sar_trial;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conversion_done_irq_o <= 1'b0;
    end else begin
      conversion_done_irq_o <= state == SAS_RUN && sar_done && !stop_mode_i;
    end
  end

  // eight decisions spread over the conversion
  sas_step_timer #(.CW(11)) u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(start_req && state == SAS_IDLE),
    .run_i(state == SAS_RUN && !stop_mode_i),
    .step_len_i(step_len),
    .tick_o(step_tick)
  );

  sas_sar_core #(.NB(NB)) u_sar (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(start_req && state == SAS_IDLE),
    .step_i(step_tick),
    .cmp_i(cmp_i),
    .trial_o(sar_trial),
    .done_o(sar_done)
  );

  // analog side controls, registered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_code_o <= '0;
      ladder_on_o <= 1'b0;
      sample_o <= 1'b0;
      chan_sel_o <= 4'h0;
      ain_enable_o <= 1'b0;
    end else begin
      dac_code_o <= sar_trial;
      ladder_on_o <= !stop_mode_i && (control_two[CR2_LADDER_BIT] || state == SAS_RUN);
      sample_o <= state == SAS_RUN && !stop_mode_i;
      ain_enable_o <= !control_one[CR1_AIN_DIS_BIT];
      if (control_one[CR1_CHAN_LSB +: 4] >= CHAN_ANALOG_CHANNEL_2 &&
          control_one[CR1_CHAN_LSB +: 4] <= CHAN_ANALOG_CHANNEL_5) begin
        chan_sel_o <= 4'h1 << 2'(control_one[CR1_CHAN_LSB +: 4] - CHAN_ANALOG_CHANNEL_2);
      end else begin
        chan_sel_o <= 4'h0;
      end
    end
  end

  // read mux; unstable bits return zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CONTROL_ONE: rdata_o <= control_one;
        ADDR_CONTROL_TWO: rdata_o <= {2'b00, control_two[5:0]};
        ADDR_RESULT: rdata_o <= result;
        ADDR_STATUS: rdata_o <= (8'(end_flag) << ST_END_BIT) | (8'(busy_flag) << ST_BUSY_BIT);
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // named sequences for the conversion steps
  sequence s_start;
    start_req && state == SAS_IDLE && !stop_mode_i;
  endsequence
  sequence s_finish;
    state == SAS_RUN && sar_done && !stop_mode_i;
  endsequence

  property p_start_busy;
    @(posedge clk_i) disable iff (!reset_n_i) s_start |=> busy_flag && state == SAS_RUN;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set at start");

  property p_start_selfclear;
    @(posedge clk_i) disable iff (!reset_n_i) wr_cr1 |=> !control_one[CR1_START_BIT];
  endproperty
  a_start_selfclear: assert property (p_start_selfclear) else $error("start bit stored");

  property p_finish;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_finish |=> end_flag && conversion_done_irq_o && result == $past(sar_trial);
  endproperty
  a_finish: assert property (p_finish) else $error("completion effects missing");

  property p_read_clear;
    @(posedge clk_i) disable iff (!reset_n_i) rd_result && !sar_done |=> !end_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("end flag kept after read");

  property p_busy_clear;
    @(posedge clk_i) disable iff (!reset_n_i) s_finish or stop_mode_i |=> !busy_flag;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");

  property p_restart_keep;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_start |=> !end_flag && $stable(result);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart effects wrong");

  property p_chan;
    @(posedge clk_i) disable iff (!reset_n_i)
      control_one[3:0] == CHAN_ANALOG_CHANNEL_2 |=> chan_sel_o == 4'h1;
  endproperty
  a_chan: assert property (p_chan) else $error("channel 2 not selected");

  property p_ain;
    @(posedge clk_i) disable iff (!reset_n_i)
      1'b1 |=> ain_enable_o == !$past(control_one[CR1_AIN_DIS_BIT]);
  endproperty
  a_ain: assert property (p_ain) else $error("analog enable wrong");

  property p_ladder;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == SAS_IDLE && !control_two[CR2_LADDER_BIT] |=> !ladder_on_o;
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder on while idle");

  property p_stop_regs;
    @(posedge clk_i) disable iff (!reset_n_i)
      stop_mode_i |=> control_one == CR1_RESET && control_two == CR2_RESET && state == SAS_IDLE;
  endproperty
  a_stop_regs: assert property (p_stop_regs) else $error("stop did not reset");

  property p_time_78;
    @(posedge clk_i) disable iff (!reset_n_i)
      (s_start and control_two[3:1] == TIME_78) |->
        ##[70:80] (state == SAS_IDLE || stop_mode_i);
  endproperty
  a_time_78: assert property (p_time_78) else $error("78 fc conversion too long");

  property p_status_bits;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == ADDR_STATUS |=> rdata_o[7:6] == 2'b00 && rdata_o[3:0] == 4'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status noise bits set");

  property p_ladder_run;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == SAS_RUN && !stop_mode_i |=> ladder_on_o && sample_o;
  endproperty
  a_ladder_run: assert property (p_ladder_run) else $error("ladder idle in run");

  property p_irq_pulse;
    @(posedge clk_i) disable iff (!reset_n_i) conversion_done_irq_o |=> !conversion_done_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");

  property p_stop_outputs;
    @(posedge clk_i) disable iff (!reset_n_i)
      stop_mode_i |=> !ladder_on_o && !sample_o && !busy_flag && !end_flag;
  endproperty
  a_stop_outputs: assert property (p_stop_outputs) else $error("stop not idle");

  property p_result_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(state == SAS_RUN && sar_done) && !stop_entry |=> $stable(result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");

  property p_stop_result;
    @(posedge clk_i) disable iff (!reset_n_i) stop_entry |=> result == RESULT_RESET;
  endproperty
  a_stop_result: assert property (p_stop_result) else $error("result not cleared");
endmodule
`default_nettype wire

/* design/sas_pkg.sv */
// package: register map, field layout and timing for the adc sequencer
package sas_pkg;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h0E;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h0F;
  localparam logic [7:0] ADDR_RESULT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h21;
  localparam int CR1_START_BIT = 7;
  localparam int CR1_BIT6 = 6;
  localparam int CR1_BIT5 = 5;
  localparam int CR1_AIN_DIS_BIT = 4;
  localparam int CR1_CHAN_LSB = 0;
  localparam int CR2_LADDER_BIT = 5;
  localparam int CR2_TIME_LSB = 1;
  localparam int ST_END_BIT = 5;
  localparam int ST_BUSY_BIT = 4;
  localparam logic [7:0] CR1_RESET = 8'h10;
  localparam logic [7:0] CR2_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [3:0] CHAN_ANALOG_CHANNEL_2 = 4'h2;
  localparam logic [3:0] CHAN_ANALOG_CHANNEL_5 = 4'h5;
  localparam logic [2:0] TIME_78 = 3'h2;
  localparam logic [2:0] TIME_156 = 3'h3;
  localparam logic [2:0] TIME_312 = 3'h4;
  localparam logic [2:0] TIME_624 = 3'h5;
  localparam logic [2:0] TIME_1248 = 3'h6;
  // conversion time in fc periods for each legal code
  localparam int CONV_FC_78 = 78;
  localparam int CONV_FC_156 = 156;
  localparam int CONV_FC_312 = 312;
  localparam int CONV_FC_624 = 624;
  localparam int CONV_FC_1248 = 1248;
  localparam int SAR_BITS = 8;
  typedef enum logic [1:0] {SAS_IDLE, SAS_RUN} sas_state_t;
endpackage

/* design/sas_step_timer.sv */
// step timer: splits a conversion time into equal comparator steps
`timescale 1ns/1ps
`default_nettype none
module sas_step_timer #(
  parameter int CW = 11
) (
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic clear_i, // restart count
  input wire logic run_i, // count while high
  input wire logic [CW-1:0] step_len_i, // cycles per step
  output logic tick_o // one-cycle step pulse
);
  logic [CW-1:0] count;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (clear_i || !run_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (count + 1'b1 >= step_len_i) begin
      count <= '0;
      tick_o <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* design/sas_sar_core.sv */
// successive approximation register: one decision per step, msb first
`timescale 1ns/1ps
`default_nettype none
module sas_sar_core #(
  parameter int NB = 8
) (
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic load_i, // begin a new approximation
  input wire logic step_i, // take one comparator decision
  input wire logic cmp_i, // comparator: input above trial
  output logic [NB-1:0] trial_o, // trial code to the ladder
  output logic done_o // last decision taken, one cycle
);
  logic [NB-1:0] mask;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trial_o <= '0;
      mask <= '0;
      done_o <= 1'b0;
    end else if (load_i) begin
      trial_o <= {1'b1, {(NB-1){1'b0}}};
      mask <= {1'b1, {(NB-1){1'b0}}};
      done_o <= 1'b0;
    end else if (step_i && mask != '0) begin
      trial_o <= (cmp_i ? trial_o : (trial_o & ~mask)) | (mask >> 1);
      mask <= mask >> 1;
      done_o <= (mask == {{(NB-1){1'b0}}, 1'b1});
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the adc sequencer, with a register and result model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sas_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic cmp_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] dac_code_o;
  logic ladder_on_o;
  logic sample_o;
  logic [3:0] chan_sel_o;
  logic ain_enable_o;
  logic conversion_done_irq_o;
  logic [7:0] target = 8'h00;
  logic [7:0] m_cr1 = CR1_RESET;
  logic [7:0] m_cr2 = CR2_RESET;
  logic [7:0] m_res = RESULT_RESET;
  logic m_end = 1'b0;
  logic m_busy = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr_q = 32'h0001373A;
  logic irq_seen;
  time t0 = 0;
  int err_count = 0;
  int n_checks = 0;
  int conv_len[7] = '{0, 0, CONV_FC_78, CONV_FC_156, CONV_FC_312, CONV_FC_624, CONV_FC_1248};

  sas_adc_sequencer dut_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .stop_mode_i(stop_mode_i),
    .cmp_i(cmp_i),
    .dac_code_o(dac_code_o),
    .ladder_on_o(ladder_on_o),
    .sample_o(sample_o),
    .chan_sel_o(chan_sel_o),
    .ain_enable_o(ain_enable_o),
    .conversion_done_irq_o(conversion_done_irq_o)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // a steady input level: the comparator says keep while level >= trial
  always @(posedge clk_i) begin
    cmp_i <= (target >= dac_code_o);
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] model_rd(input logic [7:0] a);
    if (a == ADDR_CONTROL_ONE) return m_cr1;
    if (a == ADDR_CONTROL_TWO) return m_cr2;
    if (a == ADDR_RESULT) return m_res;
    if (a == ADDR_STATUS) return {2'b00, m_end, m_busy, 4'h0};
    return 8'h00;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // m masks bits whose read value is left open
  task automatic rd(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] e;
    e = model_rd(a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, e & m);
    if (a == ADDR_RESULT) m_end = 1'b0;
  endtask

  task automatic start(input logic [3:0] ch, input logic [2:0] code, input logic lad);
    m_cr2 = {2'b00, lad, 1'b1, code, 1'b0};
    wr(ADDR_CONTROL_TWO, m_cr2);
    lfsr_q = lfsr_next(lfsr_q);
    target <= lfsr_q[7:0];
    exp_q.push_back(lfsr_q[7:0]);
    // channel changes here and in the reserved channel test, each time while no conversion is running
    wr(ADDR_CONTROL_ONE, {4'hA, ch});
    t0 = $time;
    m_cr1 = {4'h2, ch};
    m_busy = 1'b1;
    m_end = 1'b0;
    rd(ADDR_CONTROL_ONE, 8'hFF);
    rd(ADDR_STATUS, 8'hFF);
    chk({4'h0, chan_sel_o}, (ch >= 2 && ch <= 5) ? 8'h01 << (ch - 2) : 8'h00);
    chk({7'h0, ain_enable_o}, 8'h01);
    chk({6'h0, ladder_on_o, sample_o}, 8'h03);
  endtask

  task automatic finish(input int code, input logic rd_res);
    int n;
    int el;
    n = 0;
    while (conversion_done_irq_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      // a hung conversion ends the run at once
      chk(8'h00, 8'h01);
      results();
    end
    el = int'(($time - t0) / 20);
    chk(8'((el >= conv_len[code] - 8) && (el <= conv_len[code] + 20)), 8'h01);
    m_busy = 1'b0;
    m_end = 1'b1;
    m_res = exp_q.pop_front();
    @(posedge clk_i);
    chk({7'h0, conversion_done_irq_o}, 8'h00);
    chk(dac_code_o, m_res);
    rd(ADDR_STATUS, 8'hFF);
    if (rd_res) begin
      rd(ADDR_RESULT, 8'hFF);
      rd(ADDR_STATUS, 8'hFF);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(ADDR_CONTROL_ONE, 8'hFF);
    rd(ADDR_CONTROL_TWO, 8'h2E);
    rd(ADDR_RESULT, 8'hFF);
    rd(ADDR_STATUS, 8'hFF);
    rd(8'h00, 8'hFF);
    chk({7'h0, ain_enable_o}, 8'h00);
    $display("test reset values done");
    // only documented time codes are chosen, never a reserved one
    for (int c = 2; c <= 6; c++) begin
      start(4'(2 + (c - 2) % 4), 3'(c), 1'b0);
      rd(ADDR_CONTROL_TWO, 8'h2E);
      finish(c, 1'b1);
    end
    chk({7'h0, ladder_on_o}, 8'h00);
    $display("test time codes done");
    // second start before the first result is read
    start(4'h3, TIME_78, 1'b1);
    finish(2, 1'b0);
    start(4'h4, TIME_78, 1'b1);
    rd(ADDR_RESULT, 8'hFF);
    finish(2, 1'b1);
    chk({7'h0, ladder_on_o}, 8'h01);
    $display("test restart done");
    start(4'h5, TIME_1248, 1'b1);
    repeat (100) @(posedge clk_i);
    stop_mode_i <= 1'b1;
    m_cr1 = CR1_RESET;
    m_cr2 = CR2_RESET;
    m_busy = 1'b0;
    m_res = RESULT_RESET;
    void'(exp_q.pop_front());
    repeat (2) @(posedge clk_i);
    wr(ADDR_CONTROL_ONE, 8'hA3);
    wr(ADDR_CONTROL_TWO, 8'h3C);
    rd(ADDR_CONTROL_ONE, 8'hFF);
    rd(ADDR_CONTROL_TWO, 8'h2E);
    rd(ADDR_STATUS, 8'hFF);
    rd(ADDR_RESULT, 8'hFF);
    chk({6'h0, ladder_on_o, sample_o}, 8'h00);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    irq_seen = 1'b0;
    repeat (1400) begin
      @(posedge clk_i);
      if (conversion_done_irq_o === 1'b1) irq_seen = 1'b1;
    end
    chk({7'h0, irq_seen}, 8'h00);
    rd(ADDR_STATUS, 8'hFF);
    start(4'h2, TIME_156, 1'b0);
    finish(3, 1'b1);
    $display("test stop mode done");
    wr(ADDR_CONTROL_ONE, 8'h37);
    m_cr1 = 8'h37;
    rd(ADDR_CONTROL_ONE, 8'hFF);
    chk({4'h0, chan_sel_o}, 8'h00);
    chk({7'h0, ain_enable_o}, 8'h00);
    $display("test reserved channel done");
    results();
  end
endmodule
`default_nettype wire
